// ==== pkg/hdlc_rx_pkg.sv ====
// Constants, register map and entry layout of the overhead receiver.
// Assumes a single APB clock that also times the line bit enables.
package hdlc_rx_pkg;

  // ==================================================
  // Framing
  localparam logic [7:0] FLAG_PAT = 8'h7E;
  localparam int ABORT_ONES = 7;
  localparam logic [2:0] STUFF_ONES = 3'h5;
  localparam logic [4:0] MIN_BITS = 5'h10;
  localparam logic [3:0] WIN_FULL = 4'h8;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;

  // ==================================================
  // FIFO
  localparam int FIFO_DEPTH = 256;
  localparam int OVF_ROOM = 16;

  // ==================================================
  // Register map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] LEVEL_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] DATA_OFS = 12'h00C;
  localparam logic [11:0] PTRS_OFS = 12'h010;

  localparam int CTRL_INV = 0;
  localparam int CTRL_FCS = 1;
  localparam int CTRL_REORDER = 2;
  localparam logic [2:0] CTRL_RST = 3'h2;
  localparam logic [8:0] LEVEL_RST = 9'h001;

  localparam int ST_EMPTY = 0;
  localparam int ST_AVAIL = 1;
  localparam int ST_FULL = 2;
  localparam int ST_OVF = 3;
  localparam int ST_INVAL = 4;
  localparam int ST_LEVEL_LSB = 8;
  localparam int DATA_INVALID = 15;
  localparam int PTR_WR_LSB = 16;

  // ==================================================
  // One stored byte with its status
  typedef struct packed {
    logic fcs_err;
    logic err;
    logic eop;
    logic sop;
    logic [7:0] data;
  } rx_entry_t;

endpackage

// ==== core/rx_fifo_mem.sv ====
// Byte store of the receive FIFO, one write and one read port.
// Assumes the caller keeps addresses in range; read data is registered.
`timescale 1ns/1ps
module rx_fifo_mem
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 256,
  parameter int AW = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // ==================================================
  // Storage, left without reset to stay a plain RAM
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= '0;
    end
    else if (re)
    begin
      rdata <= mem_q[raddr];
    end
  end

endmodule

// ==== core/hdlc_overhead_receiver.sv ====
// Receive HDLC overhead controller: line bits in, bytes out over APB.
// Assumes line_bit_en marks each overhead bit, synchronous to pclk.
//
// What this block does
// - Optional inversion of every incoming bit first
// - Flags or ones fill between frames discarded
// - Fewer than 16 bits between flags discarded
// - Seven ones abort packet, drop until flag
// - Zero after five ones is deleted
// - Destuffed bits packed into bytes with markers
// - Partial last byte sets invalid, aborts packet
// - Trailing five ones still a normal packet
// - FCS checked, two bytes removed, error tagged
// - FCS off passes every byte through
// - Reorder picks first bit to 0 or 7
// - 256-byte FIFO holds bytes with status
// - Empty, full and level-based available flags
// - Start byte while full dropped, overflow
// - Other byte while full aborts packet, overflow
// - After overflow wait for start with room
// - Empty FIFO read returns invalid, no change
// - CRC-16 x16+x12+x5+1, inverted check value
// - Line and host sides work independently
`timescale 1ns/1ps
module hdlc_overhead_receiver
  import hdlc_rx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int ROOM = OVF_ROOM
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Overhead bit stream from the framer
  input wire logic line_bit_en,
  input wire logic line_bit
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] ROOM_CNT = (AW+1)'(ROOM);

  if (DEPTH != (1 << AW) || ROOM < 1 || ROOM > DEPTH)
  begin : g_check
    $error("DEPTH must be a power of two and ROOM within it");
  end

  // ==================================================
  // Registers seen by software
  logic [2:0] ctrl_q;
  logic [8:0] level_q;
  logic ovf_q;
  logic inval_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic avail_q;

  // ==================================================
  // Line side state
  logic [7:0] win_q;
  logic [3:0] wcnt_q;
  logic [2:0] ones_q;
  logic open_q;
  logic end_pend_q;
  logic abort_pend_q;
  logic [2:0] ds_ones_q;
  logic [2:0] bitcnt_q;
  logic [7:0] byte_q;
  logic [4:0] nbits_q;
  logic [15:0] crc_q;
  logic [7:0] hold_q [3];
  logic [1:0] hcnt_q;
  logic sent_q;
  rx_entry_t emit_q;
  logic emit_v_q;
  logic inval_set_q;

  // ==================================================
  // FIFO state
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic drop_q;
  rx_entry_t last_q;
  rx_entry_t rd_entry;

  // ==================================================
  // Line side decode
  logic rx_bit;
  logic [7:0] win_d;
  logic flag_hit;
  logic abort_hit;
  logic proc;
  logic old_bit;
  logic take;
  logic byte_done;
  logic [2:0] pos;
  logic [7:0] new_byte;
  logic [1:0] need;
  logic pkt_clr;
  logic [15:0] crc_d;

  always_comb
  begin
    rx_bit = line_bit ^ ctrl_q[CTRL_INV];
    win_d = {win_q[6:0], rx_bit};
    flag_hit = line_bit_en && (win_d == FLAG_PAT);
    abort_hit = line_bit_en && open_q && rx_bit && (ones_q == 3'(ABORT_ONES - 1));
    // Bits leave the window only once it is full, so flag bits never reach data
    // fill kept out of data
    proc = line_bit_en && open_q && (wcnt_q == WIN_FULL) && !abort_hit;
    old_bit = win_q[7];
    take = proc && !(ds_ones_q == STUFF_ONES && !old_bit);
    byte_done = take && (bitcnt_q == 3'h7);
    pos = ctrl_q[CTRL_REORDER] ? 3'h7 - bitcnt_q : bitcnt_q;
    new_byte = byte_q;
    new_byte[pos] = old_bit;
    need = ctrl_q[CTRL_FCS] ? 2'h3 : 2'h1;
    pkt_clr = end_pend_q || abort_pend_q || (flag_hit && !open_q);
    crc_d = {1'b0, crc_q[15:1]} ^ ((crc_q[0] ^ old_bit) ? CRC_POLY : 16'h0000);
  end

  // ==================================================
  // Raw window and ones run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      win_q <= 8'h00;
      wcnt_q <= 4'h0;
      ones_q <= 3'h0;
    end
    else if (line_bit_en)
    begin
      win_q <= win_d;
      wcnt_q <= flag_hit ? 4'h0 : (wcnt_q == WIN_FULL ? WIN_FULL : wcnt_q + 4'h1);
      ones_q <= rx_bit ? (ones_q == 3'h7 ? 3'h7 : ones_q + 3'h1) : 3'h0;
    end
  end

  // ==================================================
  // Frame open, end and abort
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      open_q <= 1'b0;
      end_pend_q <= 1'b0;
      abort_pend_q <= 1'b0;
    end
    else
    begin
      end_pend_q <= flag_hit && open_q;
      abort_pend_q <= abort_hit;
      if (flag_hit)
      begin
        open_q <= 1'b1;
      end
      else if (abort_hit)
      begin
        open_q <= 1'b0;
      end
    end
  end

  // ==================================================
  // Destuffing, byte assembly and CRC
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ds_ones_q <= 3'h0;
      bitcnt_q <= 3'h0;
      byte_q <= 8'h00;
      nbits_q <= 5'h00;
      crc_q <= CRC_INIT;
    end
    else if (pkt_clr)
    begin
      ds_ones_q <= 3'h0;
      bitcnt_q <= 3'h0;
      byte_q <= 8'h00;
      nbits_q <= 5'h00;
      crc_q <= CRC_INIT;
    end
    else if (proc)
    begin
      nbits_q <= (nbits_q == MIN_BITS) ? MIN_BITS : nbits_q + 5'h01;
      ds_ones_q <= (take && old_bit) ? ds_ones_q + 3'(ds_ones_q != 3'h7) : 3'h0;
      if (take)
      begin
        bitcnt_q <= bitcnt_q + 3'h1;
        byte_q <= byte_done ? 8'h00 : new_byte;
        crc_q <= crc_d;
      end
    end
  end

  // ==================================================
  // Byte hold-back and delivery to the FIFO
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_q <= '{default: 8'h00};
      hcnt_q <= 2'h0;
      sent_q <= 1'b0;
      emit_q <= '0;
      emit_v_q <= 1'b0;
      inval_set_q <= 1'b0;
    end
    else
    begin
      emit_v_q <= 1'b0;
      inval_set_q <= 1'b0;
      if (end_pend_q && nbits_q >= MIN_BITS)
      begin
        emit_v_q <= 1'b1;
        emit_q.data <= hold_q[0];
        emit_q.sop <= !sent_q;
        emit_q.eop <= 1'b1;
        emit_q.err <= (bitcnt_q != 3'h0) || (ctrl_q[CTRL_FCS] && hcnt_q != 2'h3);
        emit_q.fcs_err <= ctrl_q[CTRL_FCS] && bitcnt_q == 3'h0 && hcnt_q == 2'h3 && crc_q != CRC_GOOD;
        inval_set_q <= bitcnt_q != 3'h0;
      end
      else if (abort_pend_q && (sent_q || hcnt_q != 2'h0))
      begin
        emit_v_q <= 1'b1;
        emit_q.data <= hold_q[0];
        emit_q.sop <= !sent_q;
        emit_q.eop <= 1'b1;
        emit_q.err <= 1'b1;
        emit_q.fcs_err <= 1'b0;
      end
      // FCS off holds one byte only
      else if (byte_done && hcnt_q == need)
      begin
        emit_v_q <= 1'b1;
        emit_q.data <= hold_q[0];
        emit_q.sop <= !sent_q;
        emit_q.eop <= 1'b0;
        emit_q.err <= 1'b0;
        emit_q.fcs_err <= 1'b0;
        sent_q <= 1'b1;
        hold_q[0] <= (need == 2'h1) ? new_byte : hold_q[1];
        hold_q[1] <= hold_q[2];
        hold_q[2] <= new_byte;
      end
      else if (byte_done)
      begin
        hold_q[hcnt_q] <= new_byte;
        hcnt_q <= hcnt_q + 2'h1;
      end
      if (pkt_clr)
      begin
        hcnt_q <= 2'h0;
        sent_q <= 1'b0;
      end
    end
  end

  // ==================================================
  // FIFO write side and overflow handling
  logic is_full;
  logic room_ok;
  logic wr_fire;
  logic patch;
  logic ovf_hit;
  logic drop_d;
  logic pop;
  rx_entry_t patch_entry;

  always_comb
  begin
    is_full = cnt_q == FULL_CNT;
    room_ok = (FULL_CNT - cnt_q) >= ROOM_CNT;
    wr_fire = 1'b0;
    patch = 1'b0;
    ovf_hit = 1'b0;
    drop_d = drop_q;
    patch_entry = last_q;
    patch_entry.eop = 1'b1;
    patch_entry.err = 1'b1;
    if (emit_v_q)
    begin
      if (emit_q.sop)
      begin
        if (is_full)
        begin
          ovf_hit = 1'b1;
          drop_d = 1'b1;
        end
        else if (!drop_q || room_ok)
        begin
          wr_fire = 1'b1;
          drop_d = 1'b0;
        end
      end
      else if (!drop_q)
      begin
        if (is_full)
        begin
          ovf_hit = 1'b1;
          patch = 1'b1;
          drop_d = 1'b1;
        end
        else
        begin
          wr_fire = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      drop_q <= 1'b0;
      last_q <= '0;
    end
    else
    begin
      drop_q <= drop_d;
      cnt_q <= cnt_q + (AW+1)'(wr_fire) - (AW+1)'(pop);
      if (wr_fire)
      begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
        last_q <= emit_q;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
    end
  end

  // single-clock store between the two sides
  rx_fifo_mem #(
    .WIDTH($bits(rx_entry_t)),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(pclk),
    .rst_n(presetn),
    .we(wr_fire || patch),
    .waddr(patch ? wr_ptr_q - AW'(1) : wr_ptr_q),
    .wdata(patch ? patch_entry : emit_q),
    .re(psel && !penable && !pwrite && paddr == DATA_OFS),
    .raddr(rd_ptr_q),
    .rdata(rd_entry)
  );

  // ==================================================
  // APB slave, one wait state on every transfer
  logic setup;
  logic done;

  assign setup = psel && !penable;
  assign done = psel && penable && pready_q;
  assign pop = done && !pwrite && paddr == DATA_OFS && avail_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      avail_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      if (setup)
      begin
        avail_q <= cnt_q != '0;
      end
      if (psel && penable && !pready_q)
      begin
        pslverr_q <= !(paddr inside {CTRL_OFS, LEVEL_OFS, STATUS_OFS, DATA_OFS, PTRS_OFS});
        prdata_q <= 32'h0000_0000;
        if (!pwrite)
        begin
          unique case (paddr)
            CTRL_OFS: prdata_q[2:0] <= ctrl_q;
            LEVEL_OFS: prdata_q[8:0] <= level_q;
            STATUS_OFS:
            begin
              prdata_q[ST_EMPTY] <= cnt_q == '0;
              prdata_q[ST_AVAIL] <= cnt_q >= (AW+1)'(level_q);
              prdata_q[ST_FULL] <= is_full;
              prdata_q[ST_OVF] <= ovf_q;
              prdata_q[ST_INVAL] <= inval_q;
              prdata_q[ST_LEVEL_LSB +: AW+1] <= cnt_q;
            end
            DATA_OFS:
            begin
              prdata_q[DATA_INVALID] <= !avail_q;
              prdata_q[$bits(rx_entry_t)-1:0] <= avail_q ? rd_entry : '0;
            end
            PTRS_OFS:
            begin
              prdata_q[AW-1:0] <= rd_ptr_q;
              prdata_q[PTR_WR_LSB +: AW] <= wr_ptr_q;
            end
            default: prdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Software controls; sticky flags let a new event win over its clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RST;
      level_q <= LEVEL_RST;
      ovf_q <= 1'b0;
      inval_q <= 1'b0;
    end
    else
    begin
      if (done && pwrite && paddr == CTRL_OFS)
      begin
        ctrl_q <= pwdata[2:0];
      end
      if (done && pwrite && paddr == LEVEL_OFS)
      begin
        level_q <= pwdata[8:0];
      end
      ovf_q <= ovf_hit || (ovf_q && !(done && pwrite && paddr == STATUS_OFS && pwdata[ST_OVF]));
      inval_q <= inval_set_q || (inval_q && !(done && pwrite && paddr == STATUS_OFS && pwdata[ST_INVAL]));
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule

// ==== verification/hdlc_rx_chk.sv ====
// Checker of the overhead receiver ports, bound from the bench.
// Assumes one clock and the package register map.
`timescale 1ns/1ps
module hdlc_rx_chk
  import hdlc_rx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line
  input wire logic line_bit_en,
  input wire logic line_bit
);
  logic [2:0] ctrl_q;
  logic [8:0] level_q;
  logic wr_ok;
  logic rd_ok;
  logic st_rd;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign wr_ok = pready && pwrite && !pslverr;
  assign rd_ok = pready && !pwrite && !pslverr;
  assign st_rd = rd_ok && paddr == STATUS_OFS;
  // ==========
  // Shadows, taken at the completing edge only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= CTRL_RST;
    else if (wr_ok && paddr == CTRL_OFS)
      ctrl_q <= pwdata[2:0];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level_q <= LEVEL_RST;
    else if (wr_ok && paddr == LEVEL_OFS)
      level_q <= pwdata[8:0];
  end
  // ==========
  // Properties
  a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_slverr_map: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > PTRS_OFS))
    else $error("error flag wrong for address");
  a_empty_count: assert property (st_rd |-> prdata[ST_EMPTY] == (prdata[16:8] == 9'h000))
    else $error("empty flag disagrees with count");
  a_full_count: assert property (st_rd |-> prdata[ST_FULL] == (prdata[16:8] == DEPTH))
    else $error("full flag disagrees with count");
  a_avail_level: assert property (st_rd |-> prdata[ST_AVAIL] == (prdata[16:8] >= level_q))
    else $error("available flag disagrees with level");
  a_empty_read: assert property (rd_ok && paddr == DATA_OFS && prdata[DATA_INVALID] |-> prdata[11:0] == 12'h000)
    else $error("invalid read carries data");
  a_ctrl_back: assert property (rd_ok && paddr == CTRL_OFS |-> prdata[2:0] == ctrl_q)
    else $error("control readback wrong");
  c_empty_read: cover property (rd_ok && paddr == DATA_OFS && prdata[DATA_INVALID]);
  c_full: cover property (st_rd && prdata[ST_FULL]);
  c_fcs_err: cover property (rd_ok && paddr == DATA_OFS && prdata[11]);
endmodule

// ==== verification/line_framer_model.sv ====
// Line framer model: sends flagged, stuffed overhead frames.
// Assumes one task at a time, entered right after a pclk edge.
`timescale 1ns/1ps
module line_framer_model
  import hdlc_rx_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Overhead bit stream
  output logic line_bit_en,
  output logic line_bit
);
  logic inv = 1'b0;
  int run = 0;
  initial
  begin
    line_bit_en = 1'b0;
    line_bit = 1'b0;
  end
  task automatic raw(input logic b);
    @(posedge pclk);
    line_bit_en <= 1'b1;
    line_bit <= b ^ inv;
  endtask
  // Idle data line flips, never a stale bit
  task automatic stop();
    @(posedge pclk);
    line_bit_en <= 1'b0;
    line_bit <= ~line_bit;
  endtask
  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      raw(b[i]);
      run = b[i] ? run + 1 : 0;
      if (run == 5)
      begin
        raw(1'b0);
        run = 0;
      end
    end
  endtask
  task automatic flag();
    for (int i = 0; i < 8; i++)
      raw(FLAG_PAT[i]);
    run = 0;
  endtask
  task automatic ones(input int n);
    repeat (n) raw(1'b1);
  endtask
  task automatic frame(input logic [7:0] pl[$], input logic fcs, input logic bad);
    logic [15:0] c;
    c = CRC_INIT;
    flag();
    foreach (pl[i])
    begin
      bits(pl[i], 8);
      for (int k = 0; k < 8; k++)
        c = (c >> 1) ^ ((c[0] ^ pl[i][k]) ? CRC_POLY : 16'h0000);
    end
    c = ~c ^ {15'h0000, bad};
    if (fcs)
    begin
      bits(c[7:0], 8);
      bits(c[15:8], 8);
    end
    flag();
    stop();
  endtask
endmodule

// ==== verification/tb_hdlc_overhead_receiver.sv ====
// Bench of the overhead receiver: APB host and entry queue model.
// Assumes the framer model and checker files beside it.
`timescale 1ns/1ps
module tb_hdlc_overhead_receiver
  import hdlc_rx_pkg::*;
();
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic line_bit_en;
  logic line_bit;
  rx_entry_t mq[$];
  logic [7:0] pl[$];
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int pushed = 0;
  always #5 pclk = ~pclk;
  hdlc_overhead_receiver DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_bit_en(line_bit_en), .line_bit(line_bit));
  line_framer_model framer (.pclk(pclk), .line_bit_en(line_bit_en), .line_bit(line_bit));
  // ==========
  // Tasks
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    check(n, r & m, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic fill(input int n);
    pl = {};
    repeat (n) pl.push_back(8'($urandom));
  endtask
  task automatic expect_frame(input int n, input logic ro, input logic fe, input logic ab);
    logic [7:0] b;
    for (int i = 0; i < n; i++)
    begin
      b = pl[i];
      if (ro)
        b = {<<{pl[i]}};
      mq.push_back({fe && i == n - 1, ab && i == n - 1, i == n - 1, i == 0, b});
      pushed++;
    end
  endtask
  task automatic drain();
    repeat (4) @(posedge pclk);
    rd(STATUS_OFS, 32'h0001_FF00, 32'(mq.size()) << 8, "fill count");
    while (mq.size() > 0)
      rd(DATA_OFS, 32'h0000_FFFF, {20'h0_0000, mq.pop_front()}, "fifo entry");
    rd(DATA_OFS, 32'hFFFF_FFFF, 32'h0000_8000, "empty read");
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  // ==========
  // Sequence
  initial
  begin
    void'($urandom(41));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CTRL_OFS, 32'h0000_0007, {29'h0, CTRL_RST}, "ctrl reset");
    rd(LEVEL_OFS, 32'h0000_01FF, {23'h0, LEVEL_RST}, "level reset");
    rd(STATUS_OFS, 32'h0001_FF1F, 32'h0000_0001, "status reset");
    rd(12'h020, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    drain();
    for (int m = 0; m < 8; m++)
    begin
      wr(CTRL_OFS, 32'(m));
      framer.inv = m[0];
      fill(2 + $urandom % 5);
      pl.push_back(8'hF8);
      expect_frame(pl.size(), m[2], m[1] && m[0], 1'b0);
      framer.frame(pl, m[1], m[1] && m[0]);
      if (m[0])
        framer.ones(3 + m);
      else
        framer.flag();
      framer.stop();
      drain();
    end
    wr(CTRL_OFS, 32'h0000_0000);
    framer.inv = 1'b0;
    pl = {8'h5A};
    framer.frame(pl, 1'b0, 1'b0);
    drain();
    for (int k = 0; k < 2; k++)
    begin
      fill(3);
      // Abort (k 0) loses the third byte still in the window; a partial tail (k 1) keeps all three
      expect_frame(2 + k, 1'b0, 1'b0, 1'b1);
      framer.flag();
      foreach (pl[i])
        framer.bits(pl[i], 8);
      if (k == 0)
        framer.ones(9);
      else
        framer.bits(8'h05, 4);
      framer.flag();
      framer.stop();
      drain();
    end
    rd(STATUS_OFS, 32'h0000_0010, 32'h0000_0010, "invalid flag");
    wr(STATUS_OFS, 32'h0000_0010);
    wr(LEVEL_OFS, 32'h0000_0100);
    fill(258);
    expect_frame(256, 1'b0, 1'b0, 1'b1);
    framer.frame(pl, 1'b0, 1'b0);
    fill(3);
    framer.frame(pl, 1'b0, 1'b0);
    repeat (4) @(posedge pclk);
    rd(STATUS_OFS, 32'h0001_FF0F, 32'h0001_000E, "full status");
    drain();
    wr(STATUS_OFS, 32'h0000_0008);
    fill(4);
    expect_frame(4, 1'b0, 1'b0, 1'b0);
    framer.frame(pl, 1'b0, 1'b0);
    drain();
    rd(PTRS_OFS, 32'h00FF_00FF, {8'h00, 8'(pushed), 8'h00, 8'(pushed)}, "pointers");
    rd(STATUS_OFS, 32'h0000_0018, 32'h0000_0000, "flags cleared");
    give_verdict();
  end
endmodule
bind hdlc_overhead_receiver hdlc_rx_chk #(.DEPTH(DEPTH)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .line_bit_en(line_bit_en), .line_bit(line_bit));
